// >>> rtl/fpr_pkg.sv
package fpr_pkg;

    // register select codes on the byte-wide command port
    localparam logic [3:0] SEL_OT = 4'h0;
    localparam logic [3:0] SEL_UT = 4'h1;
    localparam logic [3:0] SEL_VIN_OV = 4'h2;
    localparam logic [3:0] SEL_VIN_UV = 4'h3;
    localparam logic [3:0] SEL_TON_MAX = 4'h4;
    localparam logic [3:0] SEL_RETRY_LIMIT = 4'h5;
    localparam logic [3:0] SEL_RETRY_DLY_LO = 4'h6;
    localparam logic [3:0] SEL_RETRY_DLY_HI = 4'h7;
    localparam logic [3:0] SEL_TOFF_WAIT = 4'h8;
    localparam logic [3:0] SEL_CTRL = 4'h9;
    localparam logic [3:0] SEL_SUM_BYTE = 4'hA;
    localparam logic [3:0] SEL_SUM_WORD_HI = 4'hB;
    localparam logic [3:0] SEL_INPUT_FLAGS = 4'hC;
    localparam logic [3:0] SEL_THERMAL_FLAGS = 4'hD;
    localparam logic [3:0] SEL_VOUT_FLAGS = 4'hE;

    // fault source index
    localparam int SRC_OT = 0;
    localparam int SRC_UT = 1;
    localparam int SRC_VIN_OV = 2;
    localparam int SRC_VIN_UV = 3;
    localparam int SRC_TON_MAX = 4;
    localparam int NUM_SRC = 5;

    // response register fields
    localparam int ACT_HI = 7;
    localparam int ACT_LO = 6;
    localparam int RETRY_HI = 5;
    localparam int RETRY_LO = 3;
    localparam logic [7:0] RESP_KEEP_MASK = 8'hF8;
    localparam logic [7:0] RESP_RESET = 8'h00;

    // control register bits
    localparam int CTRL_OP_ON = 0;
    localparam int CTRL_SEQ_SEL = 1;

    // flag bit positions
    localparam int FLG_OV_FAULT = 7;
    localparam int FLG_UV_FAULT = 4;
    localparam int FLG_TON_MAX = 2;
    localparam int SUM_UPPER = 7;
    localparam int SUM_INPUT_UV = 3;
    localparam int SUM_TEMP = 2;
    localparam int WHI_VOUT = 7;
    localparam int WHI_INPUT = 5;

    // retry limit encoding
    localparam logic [2:0] RETRY_NONE = 3'h0;
    localparam logic [2:0] RETRY_ENDLESS = 3'h7;

    // timing
    localparam int CLK_MHZ = 100;
    localparam int TICK_US = 200;
    localparam int TICK_CYC = TICK_US * CLK_MHZ;
    localparam int QUIET_S = 16;
    localparam int QUIET_TICKS = QUIET_S * 1000000 / TICK_US;
    localparam int RETRY_MAX_MS = 13100;
    localparam int RETRY_MAX_TICKS = RETRY_MAX_MS * 1000 / TICK_US;
    localparam int TMR_W = 17;

endpackage

// >>> rtl/fpr_tmr_if.sv
`timescale 1ns/1ps
interface fpr_tmr_if #(parameter int W = 17);
    logic start;
    logic [W-1:0] load;
    logic tick;
    logic done;
    modport ctl (output start, output load, output tick, input done);
    modport tmr (input start, input load, input tick, output done);
endinterface

// >>> rtl/fpr_tick_timer.sv
`timescale 1ns/1ps
module fpr_tick_timer #(
    parameter int W = 17
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    fpr_tmr_if.tmr t
);
    initial
    begin
        if (W < 2) $error("timer width too small");
    end

    typedef struct packed {
        logic [W-1:0] cnt;
    } fpr_tmr_st_t;

    fpr_tmr_st_t s_q, s_d;

    always_comb
    begin
        s_d = s_q;
        if (t.start)
        begin
            s_d.cnt = t.load;
        end
        else if (t.tick && s_q.cnt != '0)
        begin
            s_d.cnt = s_q.cnt - 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // done while idle at zero; start in same cycle wins
    assign t.done = (s_q.cnt == '0) && !t.start;
endmodule // fpr_tick_timer

// >>> rtl/fpr_fault_policy.sv
`timescale 1ns/1ps
module fpr_fault_policy #(
    parameter int TICK_CYCLES = fpr_pkg::TICK_CYC,
    parameter int QUIET_TICKS = fpr_pkg::QUIET_TICKS,
    parameter int RETRY_MAX_TICKS = fpr_pkg::RETRY_MAX_TICKS,
    parameter logic [7:0] RESP_RESET = fpr_pkg::RESP_RESET
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic wr_en_i,
    input wire logic rd_en_i,
    input wire logic [3:0] sel_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o,
    input wire logic flt_ot_i,
    input wire logic flt_ut_i,
    input wire logic flt_vin_ov_i,
    input wire logic flt_vin_uv_i,
    input wire logic flt_ton_max_i,
    input wire logic chan_on_pin_i,
    output logic chan_en_o,
    output logic host_alert_line_n_o
);
    localparam int NS = fpr_pkg::NUM_SRC;
    localparam int TW = fpr_pkg::TMR_W;
    localparam int TCW = $clog2(TICK_CYCLES + 1);

    initial
    begin
        if (TICK_CYCLES < 1) $error("tick period too short");
        if (QUIET_TICKS >= (1 << TW)) $error("quiet count too wide");
        if (RETRY_MAX_TICKS >= (1 << 16)) $error("retry clamp too wide");
    end

    ////////////////////////////////////////////////////////////////////////

    typedef enum logic [2:0] {
        CH_OFF_CMD,
        CH_ON,
        CH_SEQ_OFF,
        CH_RETRY_WAIT,
        CH_FAULT_HOLD
    } fpr_ch_t;

    typedef struct packed {
        logic [NS-1:0][7:0] resp;
        logic [2:0] retry_lim;
        logic [15:0] retry_dly;
        logic [15:0] toff_wait;
        logic op_on;
        logic seq_sel;
        logic [7:0] in_flags;
        logic [7:0] th_flags;
        logic [7:0] vo_flags;
        fpr_ch_t ch;
        logic [2:0] retry_cnt;
        logic [NS-1:0] act_retry;
        logic [2:0] act_lim;
        logic pend_retry;
        logic pin_s1;
        logic pin_s2;
        logic [TCW-1:0] tick_cnt;
        logic [7:0] rdata;
        logic chan_en;
        logic alert_n;
    } fpr_st_t;

    fpr_st_t s_q, s_d;

    fpr_tmr_if #(.W(TW)) seq_t ();
    fpr_tmr_if #(.W(TW)) quiet_t ();

    fpr_tick_timer #(.W(TW)) u_seq_tmr (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .t(seq_t.tmr)
    );

    fpr_tick_timer #(.W(TW)) u_quiet_tmr (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .t(quiet_t.tmr)
    );

    ////////////////////////////////////////////////////////////////////////

    logic tick;
    logic on_cmd;
    logic [NS-1:0] ev;
    logic [NS-1:0] shut;
    logic retry_ok;
    logic seq_start;
    logic [TW-1:0] seq_load;
    logic [15:0] dly_clamped;
    logic [7:0] sum_byte;
    logic [7:0] sum_word_hi;
    logic [7:0] wmask;

    // fault inputs are comparator results on this clock, no sync
    assign ev = {flt_ton_max_i, flt_vin_uv_i, flt_vin_ov_i,
                 flt_ut_i, flt_ot_i};

    // the delay field is hard zero, so events act the same cycle
    always_comb
    begin
        for (int i = 0; i < NS; i++)
        begin
            shut[i] = ev[i] && (s_q.resp[i][fpr_pkg::ACT_HI:
                                            fpr_pkg::ACT_LO] != 2'h0);
        end
    end

    // restart only if every shutting source allows it
    assign retry_ok = ((shut & ~s_q.act_retry) == '0);

    // internal clamp only; stored value reads back unchanged
    assign dly_clamped = (s_q.retry_dly > 16'(RETRY_MAX_TICKS))
                       ? 16'(RETRY_MAX_TICKS) : s_q.retry_dly;

    assign on_cmd = s_q.pin_s2 && s_q.op_on;
    assign tick = (s_q.tick_cnt == TCW'(TICK_CYCLES - 1));

    assign sum_byte = {
        (s_q.vo_flags != 8'h00) || s_q.in_flags[fpr_pkg::FLG_OV_FAULT],
        3'h0,
        s_q.in_flags[fpr_pkg::FLG_UV_FAULT],
        s_q.th_flags != 8'h00,
        2'h0
    };
    assign sum_word_hi = {
        s_q.vo_flags != 8'h00,
        1'b0,
        s_q.in_flags != 8'h00,
        5'h00
    };

    assign seq_t.start = seq_start;
    assign seq_t.load = seq_load;
    assign seq_t.tick = tick;
    assign quiet_t.start = (s_q.ch != CH_ON);
    assign quiet_t.load = TW'(QUIET_TICKS);
    assign quiet_t.tick = tick;

    ////////////////////////////////////////////////////////////////////////

    always_comb
    begin
        s_d = s_q;
        seq_start = 1'b0;
        seq_load = '0;
        wmask = 8'h00;

        s_d.tick_cnt = tick ? '0 : s_q.tick_cnt + 1'b1;
        s_d.pin_s1 = chan_on_pin_i;
        s_d.pin_s2 = s_q.pin_s1;

        // register writes
        if (wr_en_i)
        begin
            wmask = wdata_i;
            unique case (sel_i)
                fpr_pkg::SEL_OT,
                fpr_pkg::SEL_UT,
                fpr_pkg::SEL_VIN_OV,
                fpr_pkg::SEL_VIN_UV,
                fpr_pkg::SEL_TON_MAX:
                    s_d.resp[sel_i] = wdata_i & fpr_pkg::RESP_KEEP_MASK;
                fpr_pkg::SEL_RETRY_LIMIT: s_d.retry_lim = wdata_i[2:0];
                fpr_pkg::SEL_RETRY_DLY_LO: s_d.retry_dly[7:0] = wdata_i;
                fpr_pkg::SEL_RETRY_DLY_HI: s_d.retry_dly[15:8] = wdata_i;
                fpr_pkg::SEL_TOFF_WAIT: s_d.toff_wait[7:0] = wdata_i;
                fpr_pkg::SEL_CTRL:
                begin
                    s_d.op_on = wdata_i[fpr_pkg::CTRL_OP_ON];
                    s_d.seq_sel = wdata_i[fpr_pkg::CTRL_SEQ_SEL];
                end
                fpr_pkg::SEL_INPUT_FLAGS: s_d.in_flags = s_q.in_flags & ~wmask;
                fpr_pkg::SEL_THERMAL_FLAGS:
                    s_d.th_flags = s_q.th_flags & ~wmask;
                fpr_pkg::SEL_VOUT_FLAGS: s_d.vo_flags = s_q.vo_flags & ~wmask;
                default: ;
            endcase
        end

        // flag set after write-one-clear so a same-cycle event survives
        if (ev[fpr_pkg::SRC_OT])
            s_d.th_flags[fpr_pkg::FLG_OV_FAULT] = 1'b1;
        if (ev[fpr_pkg::SRC_UT])
            s_d.th_flags[fpr_pkg::FLG_UV_FAULT] = 1'b1;
        if (ev[fpr_pkg::SRC_VIN_OV])
            s_d.in_flags[fpr_pkg::FLG_OV_FAULT] = 1'b1;
        if (ev[fpr_pkg::SRC_VIN_UV])
            s_d.in_flags[fpr_pkg::FLG_UV_FAULT] = 1'b1;
        if (ev[fpr_pkg::SRC_TON_MAX])
            s_d.vo_flags[fpr_pkg::FLG_TON_MAX] = 1'b1;

        // channel policy
        if (!on_cmd)
        begin
            s_d.ch = CH_OFF_CMD;
            s_d.retry_cnt = 3'h0;
        end
        else
        begin
            unique case (s_q.ch)
                CH_OFF_CMD:
                begin
                    // retry limit and per-source retry fields sampled only at the off-then-on edge
                    s_d.ch = CH_ON;
                    s_d.retry_cnt = 3'h0;
                    s_d.act_lim = s_q.retry_lim;
                    for (int i = 0; i < NS; i++)
                    begin
                        s_d.act_retry[i] = s_q.resp[i][fpr_pkg::RETRY_HI:
                            fpr_pkg::RETRY_LO] != 3'h0;
                    end
                end
                CH_ON:
                begin
                    if (shut != '0)
                    begin
                        s_d.pend_retry = retry_ok;
                        if (s_q.seq_sel && s_q.toff_wait != 16'h0000)
                        begin
                            s_d.ch = CH_SEQ_OFF;
                            seq_start = 1'b1;
                            seq_load = TW'(s_q.toff_wait);
                        end
                        else
                        begin
                            s_d.ch = CH_FAULT_HOLD;
                            if (retry_ok && (s_q.act_lim == fpr_pkg::RETRY_ENDLESS
                                || s_q.retry_cnt < s_q.act_lim))
                            begin
                                s_d.ch = CH_RETRY_WAIT;
                                seq_start = 1'b1;
                                seq_load = TW'(dly_clamped);
                                if (s_q.act_lim != fpr_pkg::RETRY_ENDLESS)
                                    s_d.retry_cnt = s_q.retry_cnt + 1'b1;
                            end
                        end
                    end
                    else if (quiet_t.done)
                    begin
                        s_d.retry_cnt = 3'h0;
                    end
                end
                CH_SEQ_OFF:
                begin
                    if (shut != '0)
                    begin
                        s_d.ch = CH_FAULT_HOLD;
                    end
                    else if (seq_t.done)
                    begin
                        s_d.ch = CH_FAULT_HOLD;
                        if (s_q.pend_retry
                            && (s_q.act_lim == fpr_pkg::RETRY_ENDLESS
                            || s_q.retry_cnt < s_q.act_lim))
                        begin
                            s_d.ch = CH_RETRY_WAIT;
                            seq_start = 1'b1;
                            seq_load = TW'(dly_clamped);
                            if (s_q.act_lim != fpr_pkg::RETRY_ENDLESS)
                                s_d.retry_cnt = s_q.retry_cnt + 1'b1;
                        end
                    end
                end
                CH_RETRY_WAIT:
                begin
                    if (shut != '0)
                        s_d.ch = CH_FAULT_HOLD;
                    else if (seq_t.done)
                        s_d.ch = CH_ON;
                end
                CH_FAULT_HOLD: s_d.ch = CH_FAULT_HOLD;
            endcase
        end

        // channel keeps running while the turn-off wait elapses
        s_d.chan_en = (s_d.ch == CH_ON) || (s_d.ch == CH_SEQ_OFF);

        // alert follows the sticky flags, released once all cleared
        s_d.alert_n = (s_d.in_flags == 8'h00) && (s_d.th_flags == 8'h00)
                   && (s_d.vo_flags == 8'h00);

        // register reads
        if (rd_en_i)
        begin
            unique case (sel_i)
                fpr_pkg::SEL_OT,
                fpr_pkg::SEL_UT,
                fpr_pkg::SEL_VIN_OV,
                fpr_pkg::SEL_VIN_UV,
                fpr_pkg::SEL_TON_MAX:
                    s_d.rdata = s_q.resp[sel_i] & fpr_pkg::RESP_KEEP_MASK;
                fpr_pkg::SEL_RETRY_LIMIT: s_d.rdata = {5'h00, s_q.retry_lim};
                fpr_pkg::SEL_RETRY_DLY_LO: s_d.rdata = s_q.retry_dly[7:0];
                fpr_pkg::SEL_RETRY_DLY_HI: s_d.rdata = s_q.retry_dly[15:8];
                fpr_pkg::SEL_TOFF_WAIT: s_d.rdata = s_q.toff_wait[7:0];
                fpr_pkg::SEL_CTRL:
                    s_d.rdata = {6'h00, s_q.seq_sel, s_q.op_on};
                fpr_pkg::SEL_SUM_BYTE: s_d.rdata = sum_byte;
                fpr_pkg::SEL_SUM_WORD_HI: s_d.rdata = sum_word_hi;
                fpr_pkg::SEL_INPUT_FLAGS: s_d.rdata = s_q.in_flags;
                fpr_pkg::SEL_THERMAL_FLAGS: s_d.rdata = s_q.th_flags;
                fpr_pkg::SEL_VOUT_FLAGS: s_d.rdata = s_q.vo_flags;
                default: s_d.rdata = 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////

    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            s_q <= '0;
            s_q.resp <= {NS{RESP_RESET & fpr_pkg::RESP_KEEP_MASK}};
            s_q.ch <= CH_OFF_CMD;
            s_q.alert_n <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign rdata_o = s_q.rdata;
    assign chan_en_o = s_q.chan_en;
    assign host_alert_line_n_o = s_q.alert_n;
endmodule // fpr_fault_policy

// >>> test/fpr_fault_policy_sva.sv
`timescale 1ns/1ps
module fpr_fault_policy_sva (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic wr_en_i,
    input wire logic rd_en_i,
    input wire logic [3:0] sel_i,
    input wire logic [7:0] wdata_i,
    input wire logic [7:0] rdata_o,
    input wire logic flt_ot_i,
    input wire logic flt_ut_i,
    input wire logic flt_vin_ov_i,
    input wire logic flt_vin_uv_i,
    input wire logic flt_ton_max_i,
    input wire logic chan_on_pin_i,
    input wire logic chan_en_o,
    input wire logic host_alert_line_n_o
);
    default clocking dcb @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////////////////
    // shadow of the response bytes; retry latching is not modelled,
    // so tests only change retry fields while no fault is pending
    logic [7:0] resp_q [5];
    logic seq_q;
    logic [4:0] flt;
    logic shut;
    logic no_retry;
    assign flt = {flt_ton_max_i, flt_vin_uv_i, flt_vin_ov_i, flt_ut_i,
        flt_ot_i};
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            resp_q <= '{default: 8'h00};
            seq_q <= 1'b0;
        end
        else if (wr_en_i && sel_i < 4'h5)
            resp_q[sel_i[2:0]] <= wdata_i;
        else if (wr_en_i && sel_i == fpr_pkg::SEL_CTRL)
            seq_q <= wdata_i[fpr_pkg::CTRL_SEQ_SEL];
    end
    always_comb
    begin
        shut = 1'b0;
        no_retry = 1'b1;
        for (int i = 0; i < 5; i++)
        begin
            if (flt[i] && resp_q[i][7:6] != 2'h0)
            begin
                shut = 1'b1;
                no_retry = no_retry && resp_q[i][5:3] == 3'h0;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    sequence s_held_off;
        !chan_en_o [*8];
    endsequence
    chk_alert_on_fault:
        assert property (|flt |=> !host_alert_line_n_o)
        else $error("alert not low after fault");
    chk_keep_running:
        assert property ((|flt && !shut && !seq_q && chan_en_o && !wr_en_i
            && !$past(wr_en_i) && chan_on_pin_i && $past(chan_on_pin_i)
            && $past(chan_on_pin_i, 2)) |=> chan_en_o)
        else $error("channel dropped on ignored fault");
    chk_shut_at_once:
        assert property (shut && !seq_q |=> !chan_en_o)
        else $error("channel not shut at once");
    chk_hold_no_retry:
        assert property (shut && !seq_q && no_retry |=> s_held_off)
        else $error("channel restarted without retry");
    chk_delay_bits_zero:
        assert property (rd_en_i && sel_i < 4'h5 |=> rdata_o[2:0] == 3'h0)
        else $error("delay bits read nonzero");
    chk_unmapped_zero:
        assert property (rd_en_i && sel_i == 4'hF |=> rdata_o == 8'h00)
        else $error("unmapped read nonzero");
    chk_alert_release:
        assert property ($rose(host_alert_line_n_o)
            |-> $past(wr_en_i) || $past(wr_en_i, 2))
        else $error("alert released without clear");
    chk_enable_needs_pin:
        assert property ($rose(chan_en_o)
            |-> $past(chan_on_pin_i) && $past(chan_on_pin_i, 2))
        else $error("channel on while pin off");
endmodule // fpr_fault_policy_sva

bind fpr_fault_policy fpr_fault_policy_sva u_sva (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .wr_en_i(wr_en_i),
    .rd_en_i(rd_en_i), .sel_i(sel_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
    .flt_ot_i(flt_ot_i), .flt_ut_i(flt_ut_i), .flt_vin_ov_i(flt_vin_ov_i),
    .flt_vin_uv_i(flt_vin_uv_i), .flt_ton_max_i(flt_ton_max_i),
    .chan_on_pin_i(chan_on_pin_i), .chan_en_o(chan_en_o),
    .host_alert_line_n_o(host_alert_line_n_o));

// >>> test/fpr_fault_src_model.sv
`timescale 1ns/1ps
module fpr_fault_src_model (
    input wire logic sys_clk_i,
    input wire logic fire_i,
    input wire logic [2:0] src_i,
    output logic [4:0] flt_o
);
    // one-cycle comparator event per measured fault
    // startup timeout pulses like any other source, whenever fire_i is set
    always_ff @(posedge sys_clk_i)
    begin
        flt_o <= fire_i ? (5'h01 << src_i) : 5'h00;
    end
endmodule // fpr_fault_src_model

// >>> test/fpr_fault_policy_test.sv
`timescale 1ns/1ps
module fpr_fault_policy_test;
    logic sys_clk_i, rst_i, wr_en_i, rd_en_i, chan_on_pin_i;
    logic chan_en_o, host_alert_line_n_o;
    logic [3:0] sel_i;
    logic [7:0] wdata_i, rdata_o;
    logic [4:0] flt;
    logic flt_fire;
    logic [2:0] flt_src;
    int errors, total_checks, cycles;
    // per source: flag select, flag bit, byte and word-high summary
    logic [3:0] fsel [5] = '{4'hD, 4'hD, 4'hC, 4'hC, 4'hE};
    logic [7:0] fbit [5] = '{8'h80, 8'h10, 8'h80, 8'h10, 8'h04};
    logic [7:0] sbyte [5] = '{8'h04, 8'h04, 8'h80, 8'h08, 8'h80};
    logic [7:0] sword [5] = '{8'h00, 8'h00, 8'h20, 8'h20, 8'h80};
    ////////////////////////////////////////////////////////////////////////
    // short tick, quiet and clamp counts keep the run brief
    fpr_fault_policy #(.TICK_CYCLES(4), .QUIET_TICKS(20),
        .RETRY_MAX_TICKS(10)) dut (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .wr_en_i(wr_en_i),
        .rd_en_i(rd_en_i), .sel_i(sel_i), .wdata_i(wdata_i),
        .rdata_o(rdata_o), .flt_ot_i(flt[0]), .flt_ut_i(flt[1]),
        .flt_vin_ov_i(flt[2]), .flt_vin_uv_i(flt[3]),
        .flt_ton_max_i(flt[4]), .chan_on_pin_i(chan_on_pin_i),
        .chan_en_o(chan_en_o), .host_alert_line_n_o(host_alert_line_n_o));
    fpr_fault_src_model model (.sys_clk_i(sys_clk_i), .fire_i(flt_fire),
        .src_i(flt_src), .flt_o(flt));
    ////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] %0t byte got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic check_pin(input logic got, input logic exp);
        total_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] %0t pin got %b exp %b", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] s, input logic [7:0] d);
        @(posedge sys_clk_i);
        wr_en_i <= 1'b1;
        sel_i <= s;
        wdata_i <= d;
        @(posedge sys_clk_i);
        wr_en_i <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] s, input logic [7:0] exp);
        @(posedge sys_clk_i);
        rd_en_i <= 1'b1;
        sel_i <= s;
        @(posedge sys_clk_i);
        rd_en_i <= 1'b0;
        @(posedge sys_clk_i);
        #1;
        check_byte(rdata_o, exp);
    endtask
    task automatic wait_en(input logic exp, input int max);
        int n;
        n = 0;
        while (chan_en_o !== exp && n < max)
        begin
            @(posedge sys_clk_i);
            #1;
            n++;
        end
        check_pin(chan_en_o, exp);
    endtask
    // off then on, so latched retry settings are refreshed
    task automatic cmd_on(input logic [7:0] c);
        wr(4'h9, 8'h00);
        wr(4'h9, c);
        wait_en(1'b1, 20);
    endtask
    // returns at the edge where the design takes the one-cycle event
    task automatic fire_flt(input int src);
        @(posedge sys_clk_i);
        flt_fire <= 1'b1;
        flt_src <= 3'(src);
        @(posedge sys_clk_i);
        flt_fire <= 1'b0;
        @(posedge sys_clk_i);
    endtask
    // clamped interval: 10 ticks of 4 cycles, not the written 0xFFFF
    task automatic retry_once();
        fire_flt(3);
        repeat (30) @(posedge sys_clk_i);
        #1;
        check_pin(chan_en_o, 1'b0);
        wait_en(1'b1, 30);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errors++;
            conclude();
        end
    end
    initial
    begin
        rst_i = 1'b1;
        wr_en_i = 1'b0;
        rd_en_i = 1'b0;
        sel_i = 4'h0;
        wdata_i = 8'h00;
        chan_on_pin_i = 1'b1;
        flt_fire = 1'b0;
        flt_src = 3'h0;
        repeat (8) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        #1;
        check_pin(host_alert_line_n_o, 1'b1);
        check_pin(chan_en_o, 1'b0);
        for (int s = 0; s < 16; s++)
            rd(s[3:0], 8'h00);
        for (int s = 0; s < 5; s++)
        begin
            wr(s[3:0], 8'hFF);
            rd(s[3:0], 8'hF8);
        end
        wr(4'hA, 8'hFF);
        rd(4'hA, 8'h00);
        wr(4'hF, 8'hFF);
        rd(4'hF, 8'h00);
        cmd_on(8'h01);
        for (int s = 0; s < 5; s++)
        begin
            wr(s[3:0], 8'h00);
            fire_flt(s);
            #1;
            check_pin(host_alert_line_n_o, 1'b0);
            check_pin(chan_en_o, 1'b1);
            rd(fsel[s], fbit[s]);
            rd(4'hA, sbyte[s]);
            rd(4'hB, sword[s]);
            wr(fsel[s], 8'hFF);
            repeat (2) @(posedge sys_clk_i);
            #1;
            check_pin(host_alert_line_n_o, 1'b1);
        end
        wr(4'h0, 8'h40);
        fire_flt(0);
        #1;
        check_pin(chan_en_o, 1'b0);
        repeat (100) @(posedge sys_clk_i);
        #1;
        check_pin(chan_en_o, 1'b0);
        @(posedge sys_clk_i);
        chan_on_pin_i <= 1'b0;
        repeat (6) @(posedge sys_clk_i);
        chan_on_pin_i <= 1'b1;
        #1;
        wait_en(1'b1, 20);
        wr(4'h5, 8'h01);
        wr(4'h6, 8'hFF);
        wr(4'h7, 8'hFF);
        rd(4'h6, 8'hFF);
        rd(4'h7, 8'hFF);
        wr(4'h3, 8'h48);
        cmd_on(8'h01);
        retry_once();
        fire_flt(3);
        repeat (100) @(posedge sys_clk_i);
        #1;
        check_pin(chan_en_o, 1'b0);
        cmd_on(8'h01);
        retry_once();
        repeat (120) @(posedge sys_clk_i);
        retry_once();
        wr(4'h5, 8'h07);
        cmd_on(8'h01);
        repeat (3) retry_once();
        wr(4'h8, 8'h03);
        wr(4'h0, 8'h40);
        cmd_on(8'h03);
        fire_flt(0);
        #1;
        check_pin(chan_en_o, 1'b1);
        wait_en(1'b0, 30);
        conclude();
    end
endmodule // fpr_fault_policy_test
